//--- rtl/dpt_device.sv
// Purpose: wiper register device end of the serial link
// Assumes: link pins are asynchronous, sampled on REF_CLK_I
// Notes:   a 16 bit shift path gives daisy chain pass-through
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RQ1: sample input on clock rise, select low
// RQ2: update output on clock fall
// RQ3: control bit 1 picks open drain output
// RQ4: select high: output off, standby
// RQ5: nothing accepted before first select fall
// RQ6: wiper code maps monotonically to tap
// RQ7: wipers reset to mid-scale 40h
// RQ8: map 0, 1, 10h, all reset 40h
// RQ9: bit 6 active-low shutdown, others but bit 1 zero
// RQ10: shutdown bit resets to one
// RQ11: shutdown leaves wiper registers untouched
// RQ12: slave only, mode 0
// RQ13: most significant bit first
// RQ14: first byte: opcode, five bit address
// RQ15: address 0/1 wipers, 10000 control
// RQ16: decode nop, control and addressed ops
// RQ17: write executes on select rise
// RQ18: host sends four byte read
// RQ19: echo byte third, data fourth
// RQ20: echo byte carries 111b plus address
// RQ21: input passes through to output
// RQ22: bad or short frames change nothing
// RQ23: control keeps only bits 6 and 1
module dpt_device
  import dpt_pkg::*;
(
  // clock and reset
  input  wire logic       REF_CLK_I,
  input  wire logic       RESETN_I,
  // serial link
  dpt_link_if.dev         LINK,
  // wiper and control state
  output logic [7:0]      WIPER_POS_0_O,
  output logic [7:0]      WIPER_POS_1_O,
  output logic [6:0]      TAP_0_O,
  output logic [6:0]      TAP_1_O,
  output logic            POWER_DOWN_N_O,
  output logic            SDO_OPEN_DRAIN_O
);
  logic        cs_s1_ff, cs_s2_ff, cs_d_ff;
  logic        sck_s1_ff, sck_s2_ff, sck_d_ff;
  logic        sdi_s1_ff, sdi_s2_ff;
  logic        act_ff;
  logic [15:0] sh_ff;
  logic [3:0]  cnt_ff;
  logic        full_ff;
  logic        pend_ff;
  logic [4:0]  pend_addr_ff;
  logic [7:0]  wp0_ff, wp1_ff, acc_ff;
  logic        sdo_ff, oe_ff;
  logic [6:0]  tap0_ff, tap1_ff;
  logic        cs_fall, cs_rise, sck_rise, sck_fall;
  logic        nxt_act, nxt_sdo;
  logic [15:0] nxt_sh;

  function automatic logic [4:0] eff_addr(input logic [2:0] op,
                                          input logic [4:0] a);
    eff_addr = (op == OP_RD_ACC || op == OP_WR_ACC) ? ADDR_ACC : a;
  endfunction : eff_addr

  function automatic logic [7:0] rd_reg(input logic [4:0] a,
                                        input logic [7:0] w0,
                                        input logic [7:0] w1,
                                        input logic [7:0] ac);
    case (a)
      ADDR_WP0: rd_reg = w0;
      ADDR_WP1: rd_reg = w1;
      ADDR_ACC: rd_reg = ac;
      default:  rd_reg = 8'h00;
    endcase
  endfunction : rd_reg

  function automatic logic [6:0] to_tap(input logic [7:0] code);
    to_tap = code[7] ? TAP_MAX : code[6:0];
  endfunction : to_tap

  // pin synchronisers
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      cs_s1_ff  <= 1'b0;
      cs_s2_ff  <= 1'b0;
      cs_d_ff   <= 1'b0;
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_d_ff  <= 1'b0;
      sdi_s1_ff <= 1'b0;
      sdi_s2_ff <= 1'b0;
    end else begin
      cs_s1_ff  <= LINK.cs_n;
      cs_s2_ff  <= cs_s1_ff;
      cs_d_ff   <= cs_s2_ff;
      sck_s1_ff <= LINK.sck;
      sck_s2_ff <= sck_s1_ff;
      sck_d_ff  <= sck_s2_ff;
      sdi_s1_ff <= LINK.sdi;
      sdi_s2_ff <= sdi_s1_ff;
    end
  end

  // select fall needs a high level seen after reset first
  assign cs_fall  = cs_d_ff & ~cs_s2_ff;                  // [RQ5]
  assign cs_rise  = act_ff & ~cs_d_ff & cs_s2_ff;
  assign sck_rise = act_ff & ~sck_d_ff & sck_s2_ff;        // [RQ1] [RQ12]
  assign sck_fall = act_ff & sck_d_ff & ~sck_s2_ff;        // [RQ2]
  assign nxt_sh   = {sh_ff[14:0], sdi_s2_ff};              // [RQ13]

  always_comb begin
    nxt_act = act_ff;
    if (cs_fall)
      nxt_act = 1'b1;
    else if (cs_s2_ff)
      nxt_act = 1'b0;                                      // [RQ4]
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I)
      act_ff <= 1'b0;
    else
      act_ff <= nxt_act;
  end

  // bit count within the current instruction-data pair
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      cnt_ff  <= 4'h0;
      full_ff <= 1'b0;
    end else if (cs_fall) begin
      cnt_ff  <= 4'h0;
      full_ff <= 1'b0;
    end else if (sck_rise) begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == PAIR_LAST)
        full_ff <= 1'b1;
    end
  end

  // shift path; a read in the first pair loads echo and data
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      sh_ff <= 16'h0000;
    end else if (cs_fall && pend_ff) begin
      sh_ff <= {OP_ECHO, pend_addr_ff,
                rd_reg(pend_addr_ff, wp0_ff, wp1_ff, acc_ff)}; // [RQ20]
    end else if (sck_rise) begin
      if (cnt_ff == PAIR_LAST && !full_ff
          && op_is_read(nxt_sh[15:13]))
        sh_ff <= {OP_ECHO, eff_addr(nxt_sh[15:13], nxt_sh[12:8]),
                  rd_reg(eff_addr(nxt_sh[15:13], nxt_sh[12:8]),
                         wp0_ff, wp1_ff, acc_ff)};        // [RQ19] [RQ20]
      else
        sh_ff <= nxt_sh;                                   // [RQ21]
    end
  end

  // reads left in the last pair return in the next frame
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      pend_ff      <= 1'b0;
      pend_addr_ff <= 5'h00;
    end else if (cs_fall) begin
      pend_ff <= 1'b0;
    end else if (cs_rise && full_ff && cnt_ff == 4'h0) begin
      pend_ff      <= op_is_read(sh_ff[15:13]);            // [RQ21]
      pend_addr_ff <= eff_addr(sh_ff[15:13], sh_ff[12:8]);
    end
  end

  // execute the last complete pair on select rise
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      wp0_ff <= RST_VAL;                                   // [RQ7] [RQ8]
      wp1_ff <= RST_VAL;
      acc_ff <= RST_VAL;                                   // [RQ10]
    end else if (cs_rise && full_ff && cnt_ff == 4'h0) begin // [RQ17] [RQ22]
      if (sh_ff[15:13] == OP_WR_ACC || sh_ff[15:13] == OP_WR) begin // [RQ16]
        case (eff_addr(sh_ff[15:13], sh_ff[12:8]))         // [RQ14] [RQ15]
          ADDR_WP0: wp0_ff <= sh_ff[7:0];
          ADDR_WP1: wp1_ff <= sh_ff[7:0];
          ADDR_ACC: acc_ff <= sh_ff[7:0] & ACC_MASK;       // [RQ9] [RQ23]
          default:  ;                                      // [RQ22]
        endcase
      end
    end
  end

  // serial output and its drive enable
  always_comb begin
    nxt_sdo = sdo_ff;
    if (cs_fall)
      nxt_sdo = pend_ff ? OP_ECHO[2] : sh_ff[15];
    else if (sck_fall)
      nxt_sdo = sh_ff[15];                                 // [RQ2]
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      sdo_ff <= 1'b1;
      oe_ff  <= 1'b0;
    end else begin
      sdo_ff <= nxt_sdo;
      oe_ff  <= nxt_act & (~acc_ff[ACC_OD] | ~nxt_sdo);    // [RQ3] [RQ4]
    end
  end

  // taps follow registers even in shutdown
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      tap0_ff <= RST_VAL[6:0];
      tap1_ff <= RST_VAL[6:0];
    end else begin
      tap0_ff <= to_tap(wp0_ff);                           // [RQ6] [RQ11]
      tap1_ff <= to_tap(wp1_ff);
    end
  end

  assign LINK.sdo         = sdo_ff;
  assign LINK.sdo_oe      = oe_ff;
  assign WIPER_POS_0_O    = wp0_ff;
  assign WIPER_POS_1_O    = wp1_ff;
  assign TAP_0_O          = tap0_ff;
  assign TAP_1_O          = tap1_ff;
  assign POWER_DOWN_N_O   = acc_ff[ACC_PDN];               // [RQ9] [RQ10]
  assign SDO_OPEN_DRAIN_O = acc_ff[ACC_OD];
endmodule : dpt_device
`default_nettype wire

//--- rtl/dpt_pkg.sv
// Purpose: shared constants for the dual wiper spi register link
// Assumes: 40 MHz system clock on both ends
// Notes:   timing counts are derived from the times in ns
package dpt_pkg;
  // instruction byte
  localparam logic [2:0] OP_NOP     = 3'h0;
  localparam logic [2:0] OP_RD_ACC  = 3'h1;
  localparam logic [2:0] OP_WR_ACC  = 3'h3;
  localparam logic [2:0] OP_RD      = 3'h4;
  localparam logic [2:0] OP_WR      = 3'h6;
  localparam logic [2:0] OP_ECHO    = 3'h7;
  // register addresses and layout
  localparam logic [4:0] ADDR_WP0   = 5'h00;
  localparam logic [4:0] ADDR_WP1   = 5'h01;
  localparam logic [4:0] ADDR_ACC   = 5'h10;
  localparam logic [7:0] RST_VAL    = 8'h40;
  localparam logic [7:0] ACC_MASK   = 8'h42;
  localparam int         ACC_PDN    = 6;
  localparam int         ACC_OD     = 1;
  localparam logic [6:0] TAP_MAX    = 7'h7f;
  localparam logic [3:0] PAIR_LAST  = 4'hf;
  // controller register map
  localparam logic [2:0] H_INSTR    = 3'h0;
  localparam logic [2:0] H_DATA     = 3'h1;
  localparam logic [2:0] H_CTRL     = 3'h2;
  localparam logic [2:0] H_STAT     = 3'h3;
  localparam logic [2:0] H_ECHO     = 3'h4;
  localparam logic [2:0] H_RDAT     = 3'h5;
  // timing
  localparam int CLK_MHZ   = 40;
  localparam int HALF_NS   = 100;
  localparam int LEAD_NS   = 250;
  localparam int LAG_NS    = 250;
  localparam int DESEL_NS  = 2000;
  localparam int HALF_CYC  = (HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int LEAD_CYC  = (LEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int LAG_CYC   = (LAG_NS * CLK_MHZ + 999) / 1000;
  localparam int DESEL_CYC = (DESEL_NS * CLK_MHZ + 999) / 1000;

  function automatic logic op_is_read(input logic [2:0] op);
    op_is_read = (op == OP_RD_ACC) || (op == OP_RD);
  endfunction : op_is_read
endpackage : dpt_pkg

//--- rtl/dpt_link_if.sv
// Purpose: serial link between controller and wiper device
// Assumes: testbench joins both ends through this interface
// Notes:   sdo_line resolves push-pull or open drain with pull-up
`timescale 1ns/100ps
`default_nettype none
interface dpt_link_if;
  logic sck;
  logic sdi;
  logic cs_n;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // undriven line reads high through the pull-up
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev  (input sck, input sdi, input cs_n,
                output sdo, output sdo_oe);
  modport host (output sck, output sdi, output cs_n,
                input sdo_line);
endinterface : dpt_link_if
`default_nettype wire

//--- rtl/dpt_host.sv
// Purpose: controller end, runs one frame per software start
// Assumes: sck made here from REF_CLK_I by a divider
// Notes:   returned bits sampled at the following sck fall
`timescale 1ns/100ps
`default_nettype none
module dpt_host
  import dpt_pkg::*;
(
  // clock and reset
  input  wire logic       REF_CLK_I,
  input  wire logic       RESETN_I,
  // serial link
  dpt_link_if.host        LINK,
  // register port
  input  wire logic [2:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic [7:0]      RDATA_O
);
  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_SHIFT, S_LAG,
                            S_GAP} dpt_hst_t;

  dpt_hst_t    st_ff;
  logic [7:0]  instr_ff, data_ff, echo_ff, rdat_ff, rd_ff;
  logic [31:0] tx_ff;
  logic [15:0] rx_ff;
  logic [6:0]  tmr_ff;
  logic [4:0]  bcnt_ff, last_ff;
  logic        rd_op_ff;
  logic        sck_ff, cs_n_ff, sdi_ff;
  logic        sdo_s1_ff, sdo_s2_ff;
  logic        start;

  assign start = WR_I && ADDR_I == H_CTRL && WDATA_I[0]
                 && st_ff == S_IDLE;

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      sdo_s1_ff <= 1'b1;
      sdo_s2_ff <= 1'b1;
    end else begin
      sdo_s1_ff <= LINK.sdo_line;
      sdo_s2_ff <= sdo_s1_ff;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      instr_ff <= 8'h00;
      data_ff  <= 8'h00;
    end else if (WR_I && ADDR_I == H_INSTR) begin
      instr_ff <= WDATA_I;
    end else if (WR_I && ADDR_I == H_DATA) begin
      data_ff <= WDATA_I;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      rd_ff <= 8'h00;
    end else if (RD_I) begin
      case (ADDR_I)
        H_INSTR: rd_ff <= instr_ff;
        H_DATA:  rd_ff <= data_ff;
        H_STAT:  rd_ff <= {7'h00, st_ff != S_IDLE};
        H_ECHO:  rd_ff <= echo_ff;
        H_RDAT:  rd_ff <= rdat_ff;
        default: rd_ff <= 8'h00;
      endcase
    end
  end

  // frame sequencer: lead, 16 or 32 bits, lag, deselect gap
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      st_ff    <= S_IDLE;
      cs_n_ff  <= 1'b1;
      sck_ff   <= 1'b0;
      sdi_ff   <= 1'b0;
      tx_ff    <= 32'h0;
      rx_ff    <= 16'h0;
      tmr_ff   <= 7'h00;
      bcnt_ff  <= 5'h00;
      last_ff  <= 5'h00;
      rd_op_ff <= 1'b0;
      echo_ff  <= 8'h00;
      rdat_ff  <= 8'h00;
    end else begin
      case (st_ff)
        S_IDLE: begin
          if (start) begin
            // select falls here, giving the device its first edge
            rd_op_ff <= op_is_read(instr_ff[7:5]);
            tx_ff    <= op_is_read(instr_ff[7:5]) ?    // [RQ18]
                        {instr_ff, 24'h0} : {instr_ff, data_ff, 16'h0};
            last_ff  <= op_is_read(instr_ff[7:5]) ? 5'h1f : 5'h0f;
            sdi_ff   <= instr_ff[7];
            cs_n_ff  <= 1'b0;
            bcnt_ff  <= 5'h00;
            tmr_ff   <= 7'(LEAD_CYC - 1);
            st_ff    <= S_LEAD;
          end
        end
        S_LEAD: begin
          if (tmr_ff == 7'h00) begin
            tmr_ff <= 7'(HALF_CYC - 1);
            st_ff  <= S_SHIFT;
          end else begin
            tmr_ff <= tmr_ff - 7'h01;
          end
        end
        S_SHIFT: begin
          if (tmr_ff != 7'h00) begin
            tmr_ff <= tmr_ff - 7'h01;
          end else begin
            tmr_ff <= 7'(HALF_CYC - 1);
            sck_ff <= ~sck_ff;
            if (sck_ff) begin
              rx_ff   <= {rx_ff[14:0], sdo_s2_ff};
              tx_ff   <= {tx_ff[30:0], 1'b0};
              sdi_ff  <= tx_ff[30];
              bcnt_ff <= bcnt_ff + 5'h01;
              if (bcnt_ff == last_ff) begin
                tmr_ff <= 7'(LAG_CYC - 1);
                st_ff  <= S_LAG;
              end
            end
          end
        end
        S_LAG: begin
          if (tmr_ff == 7'h00) begin
            cs_n_ff <= 1'b1;
            tmr_ff  <= 7'(DESEL_CYC - 1);
            st_ff   <= S_GAP;
            if (rd_op_ff) begin
              echo_ff <= rx_ff[15:8];
              rdat_ff <= rx_ff[7:0];
            end
          end else begin
            tmr_ff <= tmr_ff - 7'h01;
          end
        end
        S_GAP: begin
          if (tmr_ff == 7'h00)
            st_ff <= S_IDLE;
          else
            tmr_ff <= tmr_ff - 7'h01;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  assign LINK.sck  = sck_ff;
  assign LINK.cs_n = cs_n_ff;
  assign LINK.sdi  = sdi_ff;
  assign RDATA_O   = rd_ff;
endmodule : dpt_host
`default_nettype wire

//--- test/dpt_link_assertions.sv
// Purpose: link and state checks for the wiper register link
// Assumes: both ends on REF_CLK_I, sync active low reset
// Notes:   device sees link pins through a few sync clocks
`timescale 1ns/100ps
`default_nettype none
module dpt_link_assertions
  import dpt_pkg::*;
(
  // clock and reset
  input  wire logic       REF_CLK_I,
  input  wire logic       RESETN_I,
  // link
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       sdo,
  input  wire logic       sdo_oe,
  // device state
  input  wire logic [7:0] WIPER_POS_0_O,
  input  wire logic [7:0] WIPER_POS_1_O,
  input  wire logic [6:0] TAP_0_O,
  input  wire logic       POWER_DOWN_N_O,
  input  wire logic       SDO_OPEN_DRAIN_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);

  AST_DESEL_OFF: assert property (cs_n [*8] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  AST_OUT_HOLD: assert property (!cs_n && sck && $past(sck)
    && $past(sck, 2) |-> $stable(sdo)) else $error("sdo moved in high");
  AST_OD_LOW: assert property (!cs_n && SDO_OPEN_DRAIN_O
    && sdo_oe |-> !sdo) else $error("open drain drove high");
  AST_PP_DRIVE: assert property ((!cs_n) [*6] ##0
    !SDO_OPEN_DRAIN_O |-> sdo_oe) else $error("push-pull not driven");
  AST_RST_VAL: assert property ($rose(RESETN_I) |->
    WIPER_POS_0_O == 8'h40 && WIPER_POS_1_O == 8'h40
    && POWER_DOWN_N_O && !SDO_OPEN_DRAIN_O) else $error("bad reset state");
  AST_WP0_AT_CS: assert property ($changed(WIPER_POS_0_O) |->
    cs_n && !$past(cs_n, 10)) else $error("wiper 0 moved off select rise");
  AST_WP1_AT_CS: assert property ($changed(WIPER_POS_1_O) |->
    $past(cs_n) && $past(cs_n, 2)) else $error("wiper 1 moved in frame");
  AST_PDN_KEEP: assert property ($changed(POWER_DOWN_N_O) |->
    $stable(WIPER_POS_0_O) && $stable(WIPER_POS_1_O))
    else $error("shutdown change moved a wiper");
  AST_TAP_MAP: assert property (1'b1 |=> TAP_0_O ==
    ($past(WIPER_POS_0_O[7]) ? TAP_MAX : $past(WIPER_POS_0_O[6:0])))
    else $error("tap does not follow wiper code");
  AST_IDLE_SCK: assert property (cs_n |-> !sck)
    else $error("sck active while deselected");
  AST_LEAD: assert property ($fell(cs_n) |-> (!sck) [*8])
    else $error("sck too soon after select");

  cover property ($fell(POWER_DOWN_N_O));
  cover property (!cs_n && SDO_OPEN_DRAIN_O && sdo_oe);
  cover property ($changed(WIPER_POS_1_O));
endmodule : dpt_link_assertions
`default_nettype wire

//--- test/test_spi_dual_wiper_register_slave.sv
// Purpose: self-checking bench for the wiper register link
// Assumes: host and device joined by dpt_link_if
// Notes:   expected register state kept in bench variables
`timescale 1ns/100ps
`default_nettype none
module test_spi_dual_wiper_register_slave
  import dpt_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic  [2:0] addr;
  logic  [7:0] wdata;
  logic        wr;
  logic        rd;
  logic  [7:0] rdata;
  logic  [7:0] wp0, wp1, m_wp0, m_wp1, m_acc;
  logic  [6:0] tap0, tap1;
  logic        pdn, od, pv;
  logic [15:0] pv_w;
  logic [31:0] si, so;
  int          err_total = 0;
  int          cmp_count = 0;

  dpt_link_if lnk ();
  dpt_device u_dpt_device (.REF_CLK_I(clk), .RESETN_I(rst_n), .LINK(lnk),
    .WIPER_POS_0_O(wp0), .WIPER_POS_1_O(wp1), .TAP_0_O(tap0),
    .TAP_1_O(tap1), .POWER_DOWN_N_O(pdn), .SDO_OPEN_DRAIN_O(od));
  dpt_host u_dpt_host (.REF_CLK_I(clk), .RESETN_I(rst_n), .LINK(lnk),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
  dpt_link_assertions u_chk (.REF_CLK_I(clk), .RESETN_I(rst_n),
    .sck(lnk.sck), .cs_n(lnk.cs_n), .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe),
    .WIPER_POS_0_O(wp0), .WIPER_POS_1_O(wp1), .TAP_0_O(tap0),
    .POWER_DOWN_N_O(pdn), .SDO_OPEN_DRAIN_O(od));

  // wire capture: host bits at sck rise, returned bits at sck fall
  always @(posedge lnk.sck) if (!lnk.cs_n) si <= {si[30:0], lnk.sdi};
  always @(negedge lnk.sck) if (!lnk.cs_n) so <= {so[30:0], lnk.sdo_line};

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk8(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  function automatic logic [7:0] reg_of(input logic [4:0] a);
    case (a)
      ADDR_WP0: reg_of = m_wp0;
      ADDR_WP1: reg_of = m_wp1;
      ADDR_ACC: reg_of = m_acc;
      default:  reg_of = 8'h00;
    endcase
  endfunction : reg_of

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  task automatic frame(input logic [7:0] ins, input logic [7:0] dat);
    logic [7:0] s;
    logic [4:0] ta;
    int         n;
    reg_wr(H_INSTR, ins);
    reg_wr(H_DATA, dat);
    reg_wr(H_CTRL, 8'h01);
    s = 8'h01;
    n = 0;
    while (s[0] !== 1'b0 && n < 3000) begin
      reg_rd(H_STAT, s);
      n++;
    end
    chk1("busy", 1'b0, s[0]);
    if (ins[7:5] == OP_RD || ins[7:5] == OP_RD_ACC) begin
      pv = 1'b0;
      chk8("sdi_rd", ins, si[31:24]);
    end else begin
      ta = (ins[7:5] == OP_WR_ACC) ? ADDR_ACC :
           (ins[7:5] == OP_WR) ? ins[4:0] : 5'h1f;
      if (ta == ADDR_WP0) m_wp0 = dat;
      if (ta == ADDR_WP1) m_wp1 = dat;
      if (ta == ADDR_ACC) m_acc = dat & 8'h42;
      chk8("sdi_ins", ins, si[15:8]);
      chk8("sdi_dat", dat, si[7:0]);
      if (pv) chk8("thru_hi", pv_w[15:8], so[15:8]);
      if (pv) chk8("thru_lo", pv_w[7:0], so[7:0]);
      pv_w = {ins, dat};
      pv = 1'b1;
    end
    chk8("wp0", m_wp0, wp0);
    chk8("wp1", m_wp1, wp1);
    chk8("tap0", m_wp0[7] ? 8'h7f : m_wp0, {1'b0, tap0});
    chk8("tap1", m_wp1[7] ? 8'h7f : m_wp1, {1'b0, tap1});
    chk1("pdn", m_acc[6], pdn);
    chk1("od", m_acc[1], od);
  endtask : frame

  task automatic readback(input logic [4:0] a, input logic [2:0] op);
    logic [7:0] d;
    logic [4:0] ea;
    ea = (op == OP_RD_ACC) ? ADDR_ACC : a;
    frame({op, a}, 8'h00);
    reg_rd(H_ECHO, d);
    chk8("echo", {3'b111, ea}, d);
    reg_rd(H_RDAT, d);
    chk8("rdat", reg_of(ea), d);
    chk8("sdo_echo", {3'b111, ea}, so[15:8]);
    chk8("sdo_dat", reg_of(ea), so[7:0]);
  endtask : readback

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("[ERR] watchdog expected done seen hang");
    results;
  end

  initial begin : main
    logic [7:0] d;
    logic [4:0] a;
    rst_n = 1'b0;
    addr  = 3'h0;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
    m_wp0 = 8'h40;
    m_wp1 = 8'h40;
    m_acc = 8'h40;
    pv    = 1'b0;
    void'($urandom(32'hfe36b788));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    readback(ADDR_WP0, OP_RD);
    readback(ADDR_WP1, OP_RD);
    readback(5'h0b, OP_RD_ACC);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      d = {i[1], 7'h00} | (i[0] ? 8'h7f : 8'h00);
      frame({OP_WR, ADDR_WP0}, d);
      frame({OP_WR, ADDR_WP1}, ~d);
      readback(ADDR_WP0, OP_RD);
    end
    $display("test wiper_codes done");
    frame({OP_WR_ACC, 5'h1f}, 8'hff);
    readback(ADDR_WP1, OP_RD);
    frame({OP_WR, ADDR_ACC}, 8'h02);
    readback(5'h05, OP_RD_ACC);
    frame({OP_WR_ACC, 5'h00}, 8'hbd);
    frame({OP_WR, ADDR_ACC}, 8'h40);
    $display("test access_control done");
    for (int i = 0; i < 4; i++) begin
      frame({3'(i * 2 + (i > 1)), ADDR_WP0}, 8'($urandom));
      frame({OP_WR, 5'(i * 9 + 2)}, 8'($urandom));
    end
    reg_rd(3'h7, d);
    chk8("unmapped", 8'h00, d);
    $display("test refused done");
    repeat (12) begin
      a = ($urandom % 3 == 0) ? ADDR_ACC : 5'($urandom % 2);
      frame({($urandom % 2) ? OP_WR : OP_WR_ACC, a}, 8'($urandom));
      readback(a, OP_RD);
    end
    $display("test random done");
    results;
  end
endmodule : test_spi_dual_wiper_register_slave
`default_nettype wire
